// File: hdl/lcc_logic_cluster.sv
// Purpose: Cluster of eight logic cells with shared control lines and chains
// Assumes: cfg and cellCfg are loaded before operation and held static
// Notes: Cluster clock lines act as edge ticks sampled on mclk
// Operation
// - Four shared invertible control lines for cells
// - Two lines clock, two clear or preset
// - Clock lines from pins, globals, I/O, local
// - Four-input lookup table, any function
// - Storage configurable as D, T, JK, SR
// - Combinational function bypasses the flip-flop
// - Two independent outputs, local and row
// - Carry-in feeds table and next stage
// - Long carry chains skip alternate clusters
// - Carry chain breaks at mid-row memory
// - N-bit adder in n+1 cells
// - Adder sum plain or registered accumulator
// - Cascade combines with AND or OR
// - Each cascade cell adds four inputs
// - Long cascade chains skip alternate clusters
// - Cascade chain breaks at row centre
// - Four modes: normal, arithmetic, two counters
// - Seven data inputs routed per mode
// - Three inputs give clock, clear, preset
// - Synchronous clock enable in every mode
// - Arithmetic splits into two three-input tables
// - Clearable counter ANDs load mux with clear
// - Clear and preset active low, idle high
`timescale 1ns/1ns
module lcc_logic_cluster
  import lcc_pkg::*;
#(
  parameter int CLUSTER_INDEX = 0,
  parameter int MID_INDEX = 8
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire lcc_cluster_cfg_t cfg,
  input wire lcc_cell_cfg_t [CELLS-1:0] cellCfg,
  input wire logic [PINS-1:0] clkPin,
  input wire logic [GLOBALS-1:0] globalSig,
  input wire logic [IOS-1:0] ioSig,
  input wire logic [LOCALS-1:0] localCtl,
  input wire logic [CELLS-1:0][LUT_IN-1:0] cellData,
  input wire logic carryIn,
  input wire logic cascadeIn,
  output logic carryOut,
  output logic cascadeOut,
  output logic [CELLS-1:0] localOut,
  output logic [CELLS-1:0] rowOut
);
  localparam int SYNC_W = PINS + GLOBALS + IOS;

  logic [SYNC_W-1:0] syncRaw;
  logic [SYNC_W-1:0] syncVal;
  logic [PINS-1:0] pinS;
  logic [GLOBALS-1:0] globalS;
  logic [IOS-1:0] ioS;
  logic [LINES-1:0] lineVal;
  logic [CLK_LINES-1:0] clkLevel_q;
  logic [CLK_LINES-1:0] lineTick;
  logic chainBreak;
  logic carryHead;
  logic cascadeHead;
  logic [CELLS:0] carryChain;
  logic [CELLS:0] cascChain;

  // Outside sources are synchronised before any selection logic
  assign syncRaw = {ioSig, globalSig, clkPin};

  lcc_sync2 #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async(syncRaw),
    .synced(syncVal)
  );

  assign pinS = syncVal[PINS-1:0];
  assign globalS = syncVal[PINS+GLOBALS-1:PINS];
  assign ioS = syncVal[SYNC_W-1:PINS+GLOBALS];

  // Shared control lines: source select then programmable inversion
  for (genvar l = 0; l < LINES; l++)
  begin : g_line
    logic raw;
    always_comb
    begin
      case (cfg.line[l].src)
        LCC_SRC_PIN:
        begin
          // Dedicated clock pins reach only the clock lines
          if (l < CLK_LINES)
            raw = pinS[cfg.line[l].idx[0]];
          else
            raw = CTL_IDLE_N;
        end
        LCC_SRC_GLOBAL: raw = globalS[cfg.line[l].idx];
        LCC_SRC_IO: raw = ioS[cfg.line[l].idx];
        LCC_SRC_LOCAL: raw = localCtl[cfg.line[l].idx];
        default: raw = CTL_IDLE_N;
      endcase
    end
    assign lineVal[l] = raw ^ cfg.line[l].invert;
  end

  // Clock lines become one-cycle ticks on their rising edge
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      clkLevel_q <= '0;
    else
      clkLevel_q <= lineVal[CLK_LINES-1:0];
  end

  assign lineTick = lineVal[CLK_LINES-1:0] & ~clkLevel_q;

  // Chains arrive from two clusters back and never cross the row centre
  always_comb
  begin
    chainBreak = cfg.chainStart;
    if (CLUSTER_INDEX < CHAIN_SKIP)
      chainBreak = 1'b1;
    if (CLUSTER_INDEX == MID_INDEX || CLUSTER_INDEX == MID_INDEX + 1)
      chainBreak = 1'b1;
  end

  assign carryHead = chainBreak ? cfg.carryInit : carryIn;
  assign cascadeHead = chainBreak ? cfg.cascadeInit : cascadeIn;
  assign carryChain[0] = carryHead;
  assign cascChain[0] = cascadeHead;

  for (genvar c = 0; c < CELLS; c++)
  begin : g_cell
    lcc_cell_cfg_t cc;
    logic [LUT_IN-1:0] d;
    logic cin;
    logic q;
    logic [LUT_IN-1:0] idx4;
    logic [2:0] idx3;
    logic lutOut;
    logic carryNext;
    logic combOut;
    logic loadMux;
    logic regA;
    logic regB;
    lcc_ff_t regType;
    logic ce;
    logic clrN;
    logic preN;
    logic tick;

    assign cc = cellCfg[c];
    assign d = cellData[c];
    assign cin = carryChain[c];

    // Normal mode uses four inputs; carry-in may replace the third
    assign idx4 = {d[3], cc.carryAsThird ? cin : d[2], d[1], d[0]};

    // Split-table index per mode
    always_comb
    begin
      case (cc.mode)
        LCC_MODE_ARITH: idx3 = {cin, d[2], d[1]};
        LCC_MODE_UPDOWN: idx3 = {cin, q, d[1]};
        LCC_MODE_CLRCNT: idx3 = {cin, q, 1'b1};
        default: idx3 = {cin, d[2], d[1]};
      endcase
    end

    // Table evaluation: normal mode reads the whole table; other modes lower half result, upper half carry-out
    always_comb
    begin
      case (cc.mode)
        LCC_MODE_NORMAL:
        begin
          lutOut = cc.lutMask[idx4];
          carryNext = cin;
        end
        LCC_MODE_ARITH, LCC_MODE_UPDOWN, LCC_MODE_CLRCNT:
        begin
          lutOut = cc.lutMask[{1'b0, idx3}];
          carryNext = cc.lutMask[{1'b1, idx3}];
        end
        default:
        begin
          lutOut = cc.lutMask[idx4];
          carryNext = cin;
        end
      endcase
    end

    // Cascade joins this table with the incoming chain value
    always_comb
    begin
      if (cc.useCascade && (cc.mode == LCC_MODE_NORMAL || cc.mode == LCC_MODE_ARITH))
      begin
        if (cc.cascadeOr)
          combOut = lutOut | cascChain[c];
        else
          combOut = lutOut & cascChain[c];
      end
      else
        combOut = lutOut;
    end

    // Counters: synchronous load mux; clearable form ANDs the clear
    always_comb
    begin
      loadMux = d[2] ? d[3] : lutOut;
      if (cc.mode == LCC_MODE_CLRCNT)
        loadMux = loadMux & d[1];
    end

    // Register data path per mode, with packing from the fourth input
    always_comb
    begin
      regB = d[3];
      case (cc.mode)
        LCC_MODE_NORMAL:
        begin
          regA = cc.regFromFourth ? d[3] : combOut;
          regType = cc.ffType;
          if (cc.regFromFourth)
            regB = d[2];
        end
        LCC_MODE_ARITH:
        begin
          regA = combOut;
          regType = cc.ffType;
        end
        LCC_MODE_UPDOWN, LCC_MODE_CLRCNT:
        begin
          regA = loadMux;
          regType = LCC_FF_D;
        end
        default:
        begin
          regA = combOut;
          regType = LCC_FF_D;
        end
      endcase
    end

    assign ce = cc.ceFromFirst ? d[0] : 1'b1;
    assign tick = lineTick[cc.clkLine];
    // Unused clear or preset idles high
    assign clrN = cc.useClr ? lineVal[LINE_CTL_BASE + int'(cc.clrLine)] : CTL_IDLE_N;
    assign preN = cc.usePre ? lineVal[LINE_CTL_BASE + int'(cc.preLine)] : CTL_IDLE_N;

    lcc_cell_reg u_reg (
      .mclk(mclk),
      .rst_n(rst_n),
      .clrN(clrN),
      .preN(preN),
      .tick(tick),
      .ce(ce),
      .ffType(regType),
      .dinA(regA),
      .dinB(regB),
      .q(q)
    );

    assign carryChain[c+1] = carryNext;
    assign cascChain[c+1] = combOut;

    // Two independent outputs: table result bypasses the flip-flop
    assign localOut[c] = cc.localFromReg ? q : combOut;
    assign rowOut[c] = cc.rowFromReg ? q : combOut;
  end

  assign carryOut = carryChain[CELLS];
  assign cascadeOut = cascChain[CELLS];
endmodule

// File: hdl/lcc_pkg.sv
// Purpose: Shared constants and types for the logic cluster and its cells
// Assumes: Configuration words are static while the cluster runs
// Notes: Control lines 0..1 are clock lines, 2..3 are clear/preset lines
package lcc_pkg;
  localparam int CELLS = 8;
  localparam int LINES = 4;
  localparam int CLK_LINES = 2;
  localparam int LINE_CTL_BASE = 2;
  localparam int LUT_BITS = 16;
  localparam int LUT_IN = 4;
  localparam int PINS = 2;
  localparam int GLOBALS = 4;
  localparam int IOS = 4;
  localparam int LOCALS = 4;
  localparam int SYNC_STAGES = 2;
  localparam int CHAIN_SKIP = 2;
  localparam logic REG_RESET = 1'b0;
  localparam logic REG_PRESET = 1'b1;
  localparam logic CTL_IDLE_N = 1'b1;

  typedef enum logic [1:0] {
    LCC_MODE_NORMAL = 2'b00,
    LCC_MODE_ARITH = 2'b01,
    LCC_MODE_UPDOWN = 2'b10,
    LCC_MODE_CLRCNT = 2'b11
  } lcc_mode_t;

  typedef enum logic [1:0] {
    LCC_FF_D = 2'b00,
    LCC_FF_T = 2'b01,
    LCC_FF_JK = 2'b10,
    LCC_FF_SR = 2'b11
  } lcc_ff_t;

  typedef enum logic [1:0] {
    LCC_SRC_PIN = 2'b00,
    LCC_SRC_GLOBAL = 2'b01,
    LCC_SRC_IO = 2'b10,
    LCC_SRC_LOCAL = 2'b11
  } lcc_src_t;

  typedef struct packed {
    lcc_src_t src;
    logic [1:0] idx;
    logic invert;
  } lcc_line_cfg_t;

  typedef struct packed {
    lcc_line_cfg_t [LINES-1:0] line;
    logic chainStart;
    logic carryInit;
    logic cascadeInit;
  } lcc_cluster_cfg_t;

  typedef struct packed {
    logic [LUT_BITS-1:0] lutMask;
    lcc_mode_t mode;
    lcc_ff_t ffType;
    logic clkLine;
    logic useClr;
    logic clrLine;
    logic usePre;
    logic preLine;
    logic ceFromFirst;
    logic regFromFourth;
    logic carryAsThird;
    logic useCascade;
    logic cascadeOr;
    logic localFromReg;
    logic rowFromReg;
  } lcc_cell_cfg_t;
endpackage

// File: hdl/lcc_sync2.sv
// Purpose: Two-stage synchroniser for pin, global and I/O control levels
// Assumes: Inputs are asynchronous levels
// Notes: First stage is read only by the second stage
`timescale 1ns/1ns
module lcc_sync2
  import lcc_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async;
      sync_q <= meta_q;
    end
  end

  assign synced = sync_q;
endmodule

// File: hdl/lcc_cell_reg.sv
// Purpose: Programmable storage element of one logic cell
// Assumes: Clear and preset inputs are active low
// Notes: Clear beats preset; both beat the clocked path
`timescale 1ns/1ns
module lcc_cell_reg
  import lcc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clrN,
  input wire logic preN,
  input wire logic tick,
  input wire logic ce,
  input wire lcc_ff_t ffType,
  input wire logic dinA,
  input wire logic dinB,
  output logic q
);
  logic q_q;
  logic q_d;

  // D, T, JK and SR behaviour; SR with both high holds
  always_comb
  begin
    case (ffType)
      LCC_FF_D: q_d = dinA;
      LCC_FF_T: q_d = q_q ^ dinA;
      LCC_FF_JK: q_d = (dinA & ~q_q) | (~dinB & q_q);
      LCC_FF_SR: q_d = (dinA & ~dinB) | (q_q & ~dinA & ~dinB) | (q_q & dinA & dinB);
      default: q_d = dinA;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n or negedge clrN or negedge preN)
  begin
    if (!rst_n)
      q_q <= REG_RESET;
    else if (!clrN)
      q_q <= REG_RESET;
    else if (!preN)
      q_q <= REG_PRESET;
    else if (tick && ce)
      q_q <= q_d;
  end

  // Clear and preset act as levels: releasing one while the other is still low shows at once
  assign q = (!rst_n || !clrN) ? REG_RESET : (!preN ? REG_PRESET : q_q);
endmodule

// File: tb/lcc_nbr.sv
// Purpose: Neighbouring cell that feeds the cluster's chain inputs
// Assumes: Neighbour is purely combinational
// Notes: One adder bit for carry, one AND term for cascade
`timescale 1ns/1ns
module lcc_nbr
(
  input wire logic a,
  input wire logic b,
  input wire logic c,
  output logic carry,
  output logic casc
);
  assign carry = (a & b) | (c & (a | b));
  assign casc = a & b;
endmodule

// File: tb/lcc_chk_sva.sv
// Purpose: Port checks for the logic cluster
// Assumes: Cell 0 clocked by line 0 from localCtl[0]
// Notes: Clear on line 2, preset on line 3
`timescale 1ns/1ns
module lcc_chk
  import lcc_pkg::*;
#(
  parameter int CLUSTER_INDEX = 0,
  parameter int MID_INDEX = 8
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire lcc_cluster_cfg_t cfg,
  input wire lcc_cell_cfg_t [CELLS-1:0] cellCfg,
  input wire logic [LOCALS-1:0] localCtl,
  input wire logic [CELLS-1:0][LUT_IN-1:0] cellData,
  input wire logic carryIn,
  input wire logic cascadeIn,
  input wire logic carryOut,
  input wire logic cascadeOut,
  input wire logic [CELLS-1:0] localOut,
  input wire logic [CELLS-1:0] rowOut
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  lcc_cell_cfg_t k0;
  lcc_cell_cfg_t k1;
  logic pQ;
  logic allNorm;
  logic cExp;
  logic brk;
  logic dPack;
  logic ce0;
  assign k0 = cellCfg[0];
  assign k1 = cellCfg[1];
  assign brk = CLUSTER_INDEX < 2 || CLUSTER_INDEX == MID_INDEX ||
    CLUSTER_INDEX == MID_INDEX + 1 || cfg.chainStart;
  assign dPack = k0.mode == LCC_MODE_NORMAL && k0.ffType == LCC_FF_D && !k0.clkLine &&
    k0.regFromFourth && !k0.useClr && !k0.usePre && k0.localFromReg && cfg.line[0] == 5'h18;
  assign ce0 = !k0.ceFromFirst || cellData[0][0];
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      pQ <= 1'b0;
    else
      pQ <= localCtl[0];
  // Expected cascade result when every cell is in the chain
  always_comb
  begin
    allNorm = 1'b1;
    cExp = brk ? cfg.cascadeInit : cascadeIn;
    for (int i = 0; i < CELLS; i++)
    begin
      allNorm &= cellCfg[i].mode == LCC_MODE_NORMAL && cellCfg[i].useCascade;
      allNorm &= !cellCfg[i].carryAsThird;
      if (cellCfg[i].cascadeOr)
        cExp |= cellCfg[i].lutMask[cellData[i]];
      else
        cExp &= cellCfg[i].lutMask[cellData[i]];
    end
  end
  sequence s_tick;
    localCtl[0] && !pQ && ce0;
  endsequence
  a_lut_direct: assert property (
    k0.mode == LCC_MODE_NORMAL && !k0.carryAsThird && !k0.useCascade && !k0.rowFromReg
    |-> rowOut[0] == k0.lutMask[cellData[0]]) else $error("table output wrong");
  a_dff_load: assert property (
    dPack ##0 s_tick |=> localOut[0] == $past(cellData[0][3])) else $error("load missed");
  a_ce_hold: assert property (
    dPack && !ce0 |=> $stable(localOut[0])) else $error("disabled register moved");
  a_tick_only: assert property (
    dPack && !(localCtl[0] && !pQ) |=> $stable(localOut[0])) else $error("update off tick");
  a_carry_pass: assert property (
    allNorm |-> carryOut == (brk ? cfg.carryInit : carryIn)) else $error("carry not passed");
  a_cascade_chain: assert property (
    allNorm |-> cascadeOut == cExp) else $error("cascade wrong");
  a_clear_wins: assert property (
    k1.useClr && !k1.clrLine && k1.localFromReg && cfg.line[2] == 5'h1C && !localCtl[2]
    |-> !localOut[1]) else $error("clear ignored");
  a_preset_set: assert property (
    k1.usePre && k1.preLine && !k1.clrLine && k1.localFromReg && cfg.line[3] == 5'h1E &&
    cfg.line[2] == 5'h1C && localCtl[2] && !localCtl[3] |-> localOut[1]) else $error("preset");
endmodule
bind lcc_logic_cluster lcc_chk #(.CLUSTER_INDEX(CLUSTER_INDEX), .MID_INDEX(MID_INDEX)) i_chk (
  .mclk, .rst_n, .cfg, .cellCfg, .localCtl, .cellData, .carryIn, .cascadeIn, .carryOut,
  .cascadeOut, .localOut, .rowOut);

// File: tb/tb.sv
// Purpose: Self-checking bench for the logic cluster
// Assumes: Config changes only while reset is held
// Notes: Global and I/O sources stay idle; pin 0 clocks cell 1
`timescale 1ns/1ns
module tb;
  import lcc_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  lcc_cluster_cfg_t cfg = '0;
  lcc_cell_cfg_t [CELLS-1:0] cellCfg = '0;
  logic [LOCALS-1:0] localCtl = 4'hC;
  logic [CELLS-1:0][LUT_IN-1:0] cellData = '0;
  logic nA = 1'b0;
  logic nB = 1'b0;
  logic nC = 1'b0;
  logic [PINS-1:0] clkPin = '0;
  logic midCarry;
  logic midCasc;
  logic [CELLS-1:0] midRow;
  logic carryIn;
  logic cascadeIn;
  logic carryOut;
  logic cascadeOut;
  logic [CELLS-1:0] localOut;
  logic [CELLS-1:0] rowOut;
  int badCount = 0;
  int comparisons = 0;
  always #5 mclk = ~mclk;
  lcc_nbr i_nbr (.a(nA), .b(nB), .c(nC), .carry(carryIn), .casc(cascadeIn));
  // Second cluster sits at the row centre, so its chains always restart
  lcc_logic_cluster #(.CLUSTER_INDEX(8), .MID_INDEX(8)) i_mid (.mclk(mclk), .rst_n(rst_n),
    .cfg(cfg), .cellCfg(cellCfg), .clkPin(clkPin), .globalSig(4'h0), .ioSig(4'h0),
    .localCtl(localCtl), .cellData(cellData), .carryIn(carryIn), .cascadeIn(cascadeIn),
    .carryOut(midCarry), .cascadeOut(midCasc), .localOut(), .rowOut(midRow));
  lcc_logic_cluster #(.CLUSTER_INDEX(2), .MID_INDEX(8)) i_dut (.mclk(mclk), .rst_n(rst_n),
    .cfg(cfg), .cellCfg(cellCfg), .clkPin(clkPin), .globalSig(4'h0), .ioSig(4'h0),
    .localCtl(localCtl), .cellData(cellData), .carryIn(carryIn), .cascadeIn(cascadeIn),
    .carryOut(carryOut), .cascadeOut(cascadeOut), .localOut(localOut), .rowOut(rowOut));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      badCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finishTest;
    if (badCount == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic load(input logic [2:0] brk, input lcc_cell_cfg_t [CELLS-1:0] k);
    @(negedge mclk);
    rst_n = 1'b0;
    localCtl[0] = 1'b0;
    cfg = '0;
    cfg.line[0] = 5'h18;
    cfg.line[2] = 5'h1C;
    cfg.line[3] = 5'h1E;
    {cfg.chainStart, cfg.carryInit, cfg.cascadeInit} = brk;
    cellCfg = k;
    @(negedge mclk);
    rst_n = 1'b1;
  endtask
  task automatic tick(input logic [3:0] d);
    @(negedge mclk);
    cellData[0] = d;
    localCtl[0] = 1'b0;
    @(negedge mclk);
    localCtl[0] = 1'b1;
    @(negedge mclk);
  endtask
  task automatic setCtl(input logic [1:0] v, input logic exp);
    @(negedge mclk);
    localCtl[3:2] = v;
    #1 chk(localOut[1], exp);
  endtask
  task automatic tReg;
    lcc_cell_cfg_t [CELLS-1:0] k;
    k = '0;
    k[0].lutMask = 16'h00FF;
    k[0].regFromFourth = 1'b1;
    k[0].localFromReg = 1'b1;
    k[0].ceFromFirst = 1'b1;
    k[1] = k[0];
    k[1].useClr = 1'b1;
    k[1].usePre = 1'b1;
    k[1].preLine = 1'b1;
    k[1].clkLine = 1'b1;
    load(3'h0, k);
    tick(4'h9);
    chk({localOut[0], rowOut[0]}, 16'h2);
    tick(4'h0);
    chk({localOut[0], rowOut[0]}, 16'h3);
    tick(4'h1);
    chk(localOut[0], 16'h0);
    cellData[0] = 4'h9;
    repeat (2) @(negedge mclk);
    chk(localOut[0], 16'h0);
    setCtl(2'b01, 1'b1);
    setCtl(2'b11, 1'b1);
    setCtl(2'b10, 1'b0);
    setCtl(2'b00, 1'b0);
    setCtl(2'b01, 1'b1);
    setCtl(2'b11, 1'b1);
    @(negedge mclk);
    cellData[1] = 4'h1;
    clkPin = 2'h1;
    repeat (2) @(negedge mclk);
    chk(localOut[1], 16'h1);
    @(negedge mclk);
    chk(localOut[1], 16'h0);
    clkPin = 2'h0;
  endtask
  task automatic tAdd(input logic [2:0] brk);
    lcc_cell_cfg_t [CELLS-1:0] k;
    logic [16:0] vec [3];
    logic [8:0] exp;
    logic [8:0] midExp;
    vec = '{17'h1FF01, 17'h05AA5, 17'h18080};
    k = '0;
    for (int i = 0; i < CELLS; i++)
    begin
      k[i].lutMask = 16'hE896;
      k[i].mode = LCC_MODE_ARITH;
    end
    load(brk, k);
    for (int j = 0; j < 3; j++)
    begin
      @(negedge mclk);
      nA = vec[j][16];
      nB = vec[j][16];
      nC = vec[j][16];
      for (int i = 0; i < CELLS; i++)
        cellData[i] = {1'b0, vec[j][i], vec[j][8+i], 1'b0};
      exp = vec[j][15:8] + vec[j][7:0] + (brk[2] ? brk[1] : vec[j][16]);
      midExp = vec[j][15:8] + vec[j][7:0] + brk[1];
      #1 chk({carryOut, rowOut}, exp);
      chk({midCarry, midRow}, midExp);
    end
  endtask
  task automatic tCasc(input logic [2:0] brk, input logic orMode);
    lcc_cell_cfg_t [CELLS-1:0] k;
    k = '0;
    for (int i = 0; i < CELLS; i++)
    begin
      k[i].lutMask = 16'h8000;
      k[i].useCascade = 1'b1;
      k[i].cascadeOr = orMode;
    end
    load(brk, k);
    cellData = {CELLS{orMode ? 4'h0 : 4'hF}};
    nA = 1'b1;
    nB = 1'b1;
    #1 chk(cascadeOut, 16'h1);
    chk(midCasc, brk[0]);
    cellData[5] = orMode ? 4'hF : 4'hE;
    nA = orMode ? 1'b0 : 1'b1;
    #1 chk(cascadeOut, {15'h0, orMode});
  endtask
  // Eight cells form a binary up counter on line 0; data input 2 chooses count
  task automatic tCnt(input lcc_mode_t m);
    lcc_cell_cfg_t [CELLS-1:0] k;
    k = '0;
    for (int i = 0; i < CELLS; i++)
    begin
      k[i].lutMask = 16'hC03C;
      k[i].mode = m;
      k[i].localFromReg = 1'b1;
    end
    load(3'b110, k);
    cellData = {CELLS{4'h2}};
    repeat (3) tick(4'h2);
    chk(localOut, 16'h03);
    cellData = '0;
    tick(4'h0);
    chk(localOut, (m == LCC_MODE_CLRCNT) ? 16'h00 : 16'h04);
  endtask
  initial
  begin
    #200000;
    badCount++;
    finishTest;
  end
  initial
  begin
    repeat (12) @(posedge mclk);
    tReg;
    tAdd(3'b000);
    tAdd(3'b100);
    tCasc(3'b000, 1'b0);
    tCasc(3'b101, 1'b1);
    tCnt(LCC_MODE_UPDOWN);
    tCnt(LCC_MODE_CLRCNT);
    finishTest;
  end
endmodule
